// ==== design/cps_defines.vh ====
// Purpose: constants for the configuration pin sharing block
// Assumes: included by bare name from every design file
// Notes: modes, states and timing counts
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH
// configuration modes, as detected
`define CPS_MODE_W 2
`define CPS_MODE_SSPI 2'h0
`define CPS_MODE_I2C 2'h1
`define CPS_MODE_MSPI 2'h2
`define CPS_MODE_MQSPI 2'h3
// sequencer states
`define CPS_ST_W 3
`define CPS_ST_IDLE 3'h0
`define CPS_ST_INIT 3'h1
`define CPS_ST_WAIT_INIT 3'h2
`define CPS_ST_LOAD 3'h3
`define CPS_ST_WAIT_DONE 3'h4
`define CPS_ST_USER 3'h5
// initialization time
`define CPS_INIT_NS 1000
`define CPS_CLK_NS 5
`define CPS_INIT_CYC ((`CPS_INIT_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
// boot clock divider terminal count; half period is one mclk cycle more than this count
`define CPS_BOOT_HALF 4'h4
`define CPS_BYTE_W 8
`endif

// ==== design/cps_sync.v ====
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to mclk
// Notes: first stage read only by the second
`timescale 1ns/10ps
`include "cps_defines.vh"
module cps_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // levels
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= INIT;
         sync_out <= INIT;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule // cps_sync

// ==== design/cps_skid.v ====
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: ready on the filling side is registered
`timescale 1ns/10ps
`include "cps_defines.vh"
module cps_skid #(
   parameter W = 8
) (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // filling side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // draining side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire push;
   wire pop;
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            count <= count + 2'h1;
         end else if (pop && !push) begin
            count <= count - 2'h1;
         end
      end
   end
endmodule // cps_skid

// ==== design/cps_pin_share.v ====
// Purpose: configuration pin sharing, start-up handshake and data capture
// Assumes: pin levels arrive asynchronously; link clock sampled by mclk
// Notes: open-drain pins use an active-low output enable; drive value is 0
`timescale 1ns/10ps
`include "cps_defines.vh"
// Function
// - shared pins serve configuration while configuring, user functions afterwards
// - pin set chosen from detected mode; slave modes detected at activation
// - unused shared pins stay high impedance during configuration
// - low on config request starts configuration; pin is user I/O later; code restarts configuration on a fall in user mode
// - init status is open drain, pulled low when a sequence starts
// - init status released when initialization ends; download may then start
// - download waits while init status is held low externally
// - completion pin is open drain, held low throughout configuration
// - completion pin released on successful configuration
// - wake-up waits while completion pin is held low externally
// - slave spi host drives select, clock, data; device returns serial out
// - in user mode, jtag enable routes slave spi pins to jtag
// - master spi mode drives boot clock and boot select
// - single-lane master sends on serial out, receives on serial in
// - quad mode uses four bidirectional lanes; lanes 0,1 are single pins; code never drives the lanes in quad mode
// - i2c mode uses shared sda and scl as configuration bus
// - after configuration sda/scl are gpio or user i2c
// - in user mode boot clock/select pins may be top primary clocks
// - jtag enable low gives jtag pins their configured user function
module cps_pin_share #(
   parameter INIT_CYC = `CPS_INIT_CYC,
   parameter CFG_BYTES = 16
) (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // mode straps and control
   input wire [`CPS_MODE_W-1:0] detected_mode,
   input wire jtag_enable,
   input wire load_ok,
   // config request pin
   input wire config_request_n,
   // init status pin, open drain
   input wire init_status_n_in,
   output reg init_status_n_out,
   output reg init_status_n_oe_n,
   // completion pin, open drain
   input wire done_n_in,
   output reg done_n_out,
   output reg done_n_oe_n,
   // slave spi pins
   input wire slave_select_n,
   input wire slave_clk,
   input wire slave_serial_in,
   output reg slave_serial_out,
   output reg slave_serial_out_oe_n,
   // i2c pins
   input wire sda_in,
   input wire scl_in,
   output reg sda_out,
   output reg sda_oe_n,
   // boot memory pins
   output reg boot_clk,
   output reg boot_clk_oe_n,
   output reg boot_select_n,
   output reg boot_select_n_oe_n,
   input wire [3:0] quad_lane_in,
   output reg [3:0] quad_lane_out,
   output reg [3:0] quad_lane_oe_n,
   // configuration data stream
   output reg cfg_valid,
   input wire cfg_ready,
   output reg [`CPS_BYTE_W-1:0] cfg_data,
   // status
   output reg configuring,
   output reg user_mode,
   output reg jtag_route,
   output reg user_clk_route
);
   // synchronised pin levels
   wire [9:0] pin_async;
   wire [9:0] pin_s;
   assign pin_async = {quad_lane_in, scl_in, sda_in, slave_serial_in,
                       slave_clk, slave_select_n, config_request_n};
   cps_sync #(.W(10), .INIT(10'h3ff)) u_pin_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .async_in(pin_async),
      .sync_out(pin_s)
   );
   wire [1:0] od_s;
   cps_sync #(.W(2), .INIT(2'h0)) u_od_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .async_in({done_n_in, init_status_n_in}),
      .sync_out(od_s)
   );
   wire req_n_s = pin_s[0];
   wire ss_n_s = pin_s[1];
   wire sclk_s = pin_s[2];
   wire si_s = pin_s[3];
   wire sda_s = pin_s[4];
   wire scl_s = pin_s[5];
   wire [3:0] lane_s = pin_s[9:6];
   wire init_hi_s = od_s[0];
   wire done_hi_s = od_s[1];

   reg [`CPS_ST_W-1:0] state;
   reg [`CPS_ST_W-1:0] next_state;
   reg [`CPS_MODE_W-1:0] mode;
   reg [31:0] init_cnt;
   reg [15:0] byte_cnt;
   reg req_n_d;
   reg sclk_d;
   reg scl_d;
   reg bclk_d;
   reg [3:0] div_cnt;
   reg [2:0] bit_cnt;
   reg [`CPS_BYTE_W-1:0] shreg;
   reg byte_stb;
   reg [`CPS_BYTE_W-1:0] byte_val;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [`CPS_BYTE_W-1:0] buf_out_data;
   wire loading = (state == `CPS_ST_LOAD);
   wire req_fall = req_n_d && !req_n_s;
   wire loaded = (byte_cnt == CFG_BYTES[15:0]) && !buf_out_valid;

   always @* begin
      next_state = state;
      case (state)
         `CPS_ST_IDLE: begin
            if (req_fall) begin
               next_state = `CPS_ST_INIT;
            end
         end
         `CPS_ST_INIT: begin
            if (init_cnt >= INIT_CYC) begin
               next_state = `CPS_ST_WAIT_INIT;
            end
         end
         `CPS_ST_WAIT_INIT: begin
            if (init_hi_s) begin
               next_state = `CPS_ST_LOAD;
            end
         end
         `CPS_ST_LOAD: begin
            if (loaded && load_ok) begin
               next_state = `CPS_ST_WAIT_DONE;
            end
         end
         `CPS_ST_WAIT_DONE: begin
            if (done_hi_s) begin
               next_state = `CPS_ST_USER;
            end
         end
         `CPS_ST_USER: begin
            if (req_fall) begin
               next_state = `CPS_ST_INIT;
            end
         end
         default: next_state = `CPS_ST_IDLE;
      endcase
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= `CPS_ST_IDLE;
         mode <= `CPS_MODE_SSPI;
         init_cnt <= 32'h0;
         req_n_d <= 1'b1;
      end else begin
         state <= next_state;
         req_n_d <= req_n_s;
         if (req_fall) begin
            mode <= detected_mode;
         end
         if (state == `CPS_ST_INIT) begin
            init_cnt <= init_cnt + 32'h1;
         end else begin
            init_cnt <= 32'h0;
         end
      end
   end

   // serial capture: slave spi, i2c or boot memory, by mode
   wire sclk_rise = !sclk_d && sclk_s;
   wire scl_rise = !scl_d && scl_s;
   wire bclk_rise = (div_cnt == `CPS_BOOT_HALF) && !bclk_d;
   reg shift_en;
   reg [3:0] shift_bits;
   reg [2:0] shift_n;
   always @* begin
      shift_en = 1'b0;
      shift_bits = 4'h0;
      shift_n = 3'h1;
      case (mode)
         `CPS_MODE_SSPI: begin
            shift_en = sclk_rise && !ss_n_s;
            shift_bits = {3'h0, si_s};
         end
         `CPS_MODE_I2C: begin
            shift_en = scl_rise;
            shift_bits = {3'h0, sda_s};
         end
         `CPS_MODE_MSPI: begin
            shift_en = bclk_rise;
            shift_bits = {3'h0, lane_s[1]};
         end
         `CPS_MODE_MQSPI: begin
            shift_en = bclk_rise;
            shift_bits = lane_s;
            shift_n = 3'h4;
         end
         default: shift_en = 1'b0;
      endcase
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d <= 1'b0;
         scl_d <= 1'b1;
         bclk_d <= 1'b0;
         div_cnt <= 4'h0;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         byte_stb <= 1'b0;
         byte_val <= 8'h00;
         byte_cnt <= 16'h0;
      end else begin
         sclk_d <= sclk_s;
         scl_d <= scl_s;
         byte_stb <= 1'b0;
         // boot clock from divider, stalls when buffer full
         if (loading && buf_in_ready && byte_cnt != CFG_BYTES[15:0]) begin
            if (div_cnt == `CPS_BOOT_HALF) begin
               div_cnt <= 4'h0;
               bclk_d <= ~bclk_d;
            end else begin
               div_cnt <= div_cnt + 4'h1;
            end
         end else begin
            div_cnt <= 4'h0;
            bclk_d <= 1'b0;
         end
         if (!loading) begin
            bit_cnt <= 3'h0;
            if (state != `CPS_ST_LOAD && state != `CPS_ST_WAIT_DONE) begin
               byte_cnt <= 16'h0;
            end
         end else if (shift_en && byte_cnt != CFG_BYTES[15:0]) begin
            if (shift_n == 3'h4) begin
               shreg <= {shreg[3:0], shift_bits};
            end else begin
               shreg <= {shreg[6:0], shift_bits[0]};
            end
            if (bit_cnt + shift_n == 4'h8) begin
               bit_cnt <= 3'h0;
               byte_stb <= 1'b1;
               byte_cnt <= byte_cnt + 16'h1;
               if (shift_n == 3'h4) begin
                  byte_val <= {shreg[3:0], shift_bits};
               end else begin
                  byte_val <= {shreg[6:0], shift_bits[0]};
               end
            end else begin
               bit_cnt <= bit_cnt + shift_n;
            end
         end
      end
   end

   // stall leaves a word behind only in slave modes; host must pace itself
   cps_skid #(.W(`CPS_BYTE_W)) u_buf (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(byte_stb),
      .in_ready(buf_in_ready),
      .in_data(byte_val),
      .out_valid(buf_out_valid),
      .out_ready(!cfg_valid || cfg_ready),
      .out_data(buf_out_data)
   );

   // registered pin outputs
   // next state keeps configuring in step with user_mode
   wire in_cfg = (next_state != `CPS_ST_IDLE) && (next_state != `CPS_ST_USER);
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         init_status_n_out <= 1'b0;
         init_status_n_oe_n <= 1'b1;
         done_n_out <= 1'b0;
         done_n_oe_n <= 1'b1;
         slave_serial_out <= 1'b0;
         slave_serial_out_oe_n <= 1'b1;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         boot_clk <= 1'b0;
         boot_clk_oe_n <= 1'b1;
         boot_select_n <= 1'b1;
         boot_select_n_oe_n <= 1'b1;
         quad_lane_out <= 4'h0;
         quad_lane_oe_n <= 4'hf;
         cfg_valid <= 1'b0;
         cfg_data <= 8'h00;
         configuring <= 1'b0;
         user_mode <= 1'b0;
         jtag_route <= 1'b0;
         user_clk_route <= 1'b0;
      end else begin
         init_status_n_oe_n <= !(next_state == `CPS_ST_INIT);
         done_n_oe_n <= !(next_state != `CPS_ST_WAIT_DONE &&
                          next_state != `CPS_ST_USER && next_state != `CPS_ST_IDLE);
         slave_serial_out <= shreg[7];
         slave_serial_out_oe_n <= !(loading && mode == `CPS_MODE_SSPI && !ss_n_s);
         sda_oe_n <= 1'b1;
         boot_clk <= bclk_d;
         boot_clk_oe_n <= !(loading && mode[1]);
         boot_select_n <= !(loading && mode[1]);
         boot_select_n_oe_n <= !(loading && mode[1]);
         // single-lane master: lane 0 command out until first byte; lanes inputs otherwise
         quad_lane_out <= 4'h0;
         quad_lane_oe_n <= (loading && mode == `CPS_MODE_MSPI && byte_cnt == 16'h0)
                           ? 4'he : 4'hf;
         if (cfg_valid && !cfg_ready) begin
            cfg_valid <= 1'b1;
         end else begin
            cfg_valid <= buf_out_valid;
            cfg_data <= buf_out_data;
         end
         configuring <= in_cfg;
         user_mode <= (next_state == `CPS_ST_USER);
         jtag_route <= (next_state == `CPS_ST_USER) && jtag_enable;
         // user clocks after wake-up
         user_clk_route <= (next_state == `CPS_ST_USER);
      end
   end
endmodule // cps_pin_share

// ==== sim/cps_pin_share_monitor.sv ====
// Purpose: port checks for the pin sharing block
// Assumes: bound into cps_pin_share
// Notes: init length given one cycle of slack
`timescale 1ns/10ps
module cps_pin_share_monitor #(
   parameter INIT_CYC = 200
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // pins and status
   input wire logic config_request_n,
   input wire logic init_status_n_in,
   input wire logic init_status_n_oe_n,
   input wire logic done_n_in,
   input wire logic done_n_oe_n,
   input wire logic jtag_enable,
   input wire logic jtag_route,
   input wire logic user_mode,
   input wire logic configuring,
   input wire logic boot_clk_oe_n,
   input wire logic slave_serial_out_oe_n,
   // byte stream
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic [7:0] cfg_data
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   int cnt;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
      end else begin
         cnt <= init_status_n_oe_n ? 0 : cnt + 1;
      end
   end
   property p_start;
      $fell(config_request_n) && !configuring |-> ##[2:8] !init_status_n_oe_n;
   endproperty
   a_start: assert property (p_start) else $error("init not pulled low");
   property p_init_len;
      $rose(init_status_n_oe_n) |-> cnt >= INIT_CYC - 1 && cnt <= INIT_CYC + 1;
   endproperty
   a_init_len: assert property (p_init_len) else $error("init length wrong");
   property p_done_low;
      !init_status_n_oe_n |-> !done_n_oe_n;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done not low");
   property p_hold_init;
      configuring && !init_status_n_in |=> !$rose(cfg_valid);
   endproperty
   a_hold_init: assert property (p_hold_init) else $error("load while held");
   property p_hold_done;
      !done_n_in |=> !$rose(user_mode);
   endproperty
   a_hold_done: assert property (p_hold_done) else $error("woke while held");
   property p_wake;
      $rose(user_mode) |-> done_n_oe_n && done_n_in;
   endproperty
   a_wake: assert property (p_wake) else $error("early wake-up");
   property p_user;
      user_mode |-> !configuring && done_n_oe_n && init_status_n_oe_n && boot_clk_oe_n;
   endproperty
   a_user: assert property (p_user) else $error("config pins driven in user mode");
   property p_jtag;
      (user_mode && jtag_enable) [*3] |-> jtag_route;
   endproperty
   a_jtag: assert property (p_jtag) else $error("jtag not routed");
   property p_jtag_off;
      (!jtag_enable) [*3] |-> !jtag_route;
   endproperty
   a_jtag_off: assert property (p_jtag_off) else $error("jtag routed");
   property p_master;
      !boot_clk_oe_n |-> configuring && slave_serial_out_oe_n;
   endproperty
   a_master: assert property (p_master) else $error("boot clock misdriven");
   property p_stall;
      cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data);
   endproperty
   a_stall: assert property (p_stall) else $error("byte lost");
endmodule // cps_pin_share_monitor
bind cps_pin_share cps_pin_share_monitor #(.INIT_CYC(INIT_CYC)) mon_u (.mclk(mclk),
   .rst_b(rst_b), .config_request_n(config_request_n), .init_status_n_in(init_status_n_in),
   .init_status_n_oe_n(init_status_n_oe_n), .done_n_in(done_n_in),
   .done_n_oe_n(done_n_oe_n), .jtag_enable(jtag_enable), .jtag_route(jtag_route),
   .user_mode(user_mode), .configuring(configuring), .boot_clk_oe_n(boot_clk_oe_n),
   .slave_serial_out_oe_n(slave_serial_out_oe_n), .cfg_valid(cfg_valid),
   .cfg_ready(cfg_ready), .cfg_data(cfg_data));

// ==== sim/cps_host_model.sv ====
// Purpose: configuration host model
// Assumes: open-drain pins pulled up
// Notes: link clock stands still outside frames
`timescale 1ns/10ps
module cps_host_model (
   // open-drain pins
   input wire init_status_n_oe_n,
   input wire done_n_oe_n,
   input wire hold_init,
   input wire hold_done,
   output wire init_status_n_in,
   output wire done_n_in,
   // serial pins
   output reg slave_select_n,
   output reg slave_clk,
   output reg slave_serial_in,
   output reg scl_in,
   output reg sda_in
);
   assign init_status_n_in = init_status_n_oe_n & ~hold_init;
   assign done_n_in = done_n_oe_n & ~hold_done;
   initial begin
      slave_select_n = 1'b1;
      slave_clk = 1'b0;
      slave_serial_in = 1'b0;
      scl_in = 1'b0;
      sda_in = 1'b1;
   end
   task send_byte(input [7:0] b);
      integer i;
      begin
         slave_select_n = 1'b0;
         for (i = 7; i >= 0; i = i - 1) begin
            slave_serial_in = b[i];
            sda_in = b[i];
            #40;
            slave_clk = 1'b1;
            scl_in = 1'b1;
            #40;
            slave_clk = 1'b0;
            scl_in = 1'b0;
         end
         slave_select_n = 1'b1;
         // released line must not look like held data
         slave_serial_in = ~slave_serial_in;
         sda_in = 1'b1;
         // select stays high one link period between bytes
         #80;
      end
   endtask
endmodule // cps_host_model

// ==== sim/cps_pin_share_bench.sv ====
// Purpose: self-checking bench, all four modes
// Assumes: host model drives serial and open-drain pins
// Notes: short init count and two-byte loads keep the run brief
`timescale 1ns/10ps
module cps_pin_share_bench;
   localparam IC = 20;
   localparam NB = 2;
   reg mclk = 1'b0;
   reg rst_b = 1'b0;
   reg [1:0] detected_mode = 2'h0;
   reg jtag_enable = 1'b0;
   reg load_ok = 1'b0;
   reg config_request_n = 1'b1;
   reg hold_init = 1'b0;
   reg hold_done = 1'b0;
   reg cfg_ready = 1'b0;
   reg [3:0] quad_lane_in = 4'h0;
   wire init_status_n_in, init_status_n_oe_n, done_n_in, done_n_oe_n;
   wire slave_select_n, slave_clk, slave_serial_in, scl_in, sda_in;
   wire boot_clk_oe_n, cfg_valid, configuring, user_mode, jtag_route, user_clk_route;
   wire [7:0] cfg_data;
   integer seed = 24;
   integer errors = 0;
   integer n_compared = 0;
   integer nrx, m, k, i;
   reg [31:0] rnd;
   reg [7:0] exp_q[$];
   always #2.5 mclk = ~mclk;
   cps_pin_share #(.INIT_CYC(IC), .CFG_BYTES(NB)) dut_u (.mclk(mclk), .rst_b(rst_b),
      .detected_mode(detected_mode), .jtag_enable(jtag_enable), .load_ok(load_ok),
      .config_request_n(config_request_n), .init_status_n_in(init_status_n_in),
      .init_status_n_out(), .init_status_n_oe_n(init_status_n_oe_n),
      .done_n_in(done_n_in), .done_n_out(), .done_n_oe_n(done_n_oe_n),
      .slave_select_n(slave_select_n), .slave_clk(slave_clk),
      .slave_serial_in(slave_serial_in), .slave_serial_out(), .slave_serial_out_oe_n(),
      .sda_in(sda_in), .scl_in(scl_in), .sda_out(), .sda_oe_n(), .boot_clk(),
      .boot_clk_oe_n(boot_clk_oe_n), .boot_select_n(), .boot_select_n_oe_n(),
      .quad_lane_in(quad_lane_in), .quad_lane_out(), .quad_lane_oe_n(),
      .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
      .configuring(configuring), .user_mode(user_mode), .jtag_route(jtag_route),
      .user_clk_route(user_clk_route));
   cps_host_model host_u (.init_status_n_oe_n(init_status_n_oe_n),
      .done_n_oe_n(done_n_oe_n), .hold_init(hold_init), .hold_done(hold_done),
      .init_status_n_in(init_status_n_in), .done_n_in(done_n_in),
      .slave_select_n(slave_select_n), .slave_clk(slave_clk),
      .slave_serial_in(slave_serial_in), .scl_in(scl_in), .sda_in(sda_in));
   task automatic check(input [7:0] e, input [7:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compared %0d mismatches %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task hung(input x);
      begin
         check(8'h0, {7'h0, x});
         if (x) wrap_up;
      end
   endtask
   task tick;
      begin
         @(posedge mclk);
         #1;
      end
   endtask
   // receiver stalls at random
   always @(posedge mclk) begin
      rnd = $random(seed);
      cfg_ready <= #1 rnd[0];
      if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
         nrx = nrx + 1;
         check(exp_q.pop_front(), cfg_data);
      end
   end
   initial begin
      nrx = 0;
      repeat (2) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (3) tick;
      for (m = 0; m < 4; m = m + 1) begin
         detected_mode = m[1:0];
         jtag_enable = m[0];
         load_ok = 1'b0;
         nrx = 0;
         config_request_n = 1'b0;
         for (i = 0; i < 20 && init_status_n_oe_n !== 1'b0; i = i + 1) tick;
         hung(init_status_n_oe_n !== 1'b0);
         config_request_n = 1'b1;
         hold_init = 1'b1;
         hold_done = 1'b1;
         for (i = 0; i < IC + 20 && init_status_n_oe_n !== 1'b1; i = i + 1) tick;
         hung(init_status_n_oe_n !== 1'b1);
         repeat (20) tick;
         check(8'h0, {7'h0, cfg_valid});
         check(8'h1, {7'h0, boot_clk_oe_n});
         // boot memory model: lanes hold one random nibble for the whole load
         rnd = $random(seed);
         quad_lane_in = rnd[3:0];
         for (k = 0; k < NB && m >= 2; k = k + 1)
            exp_q.push_back((m == 2) ? {8{rnd[1]}} : {rnd[3:0], rnd[3:0]});
         hold_init = 1'b0;
         repeat (8) tick;
         check({7'h0, m < 2}, {7'h0, boot_clk_oe_n});
         for (k = 0; k < NB && m < 2; k = k + 1) begin
            rnd = $random(seed);
            exp_q.push_back(rnd[7:0]);
            host_u.send_byte(rnd[7:0]);
         end
         for (i = 0; i < 3000 && nrx < NB; i = i + 1) tick;
         hung(nrx < NB);
         load_ok = 1'b1;
         for (i = 0; i < 20 && done_n_oe_n !== 1'b1; i = i + 1) tick;
         hung(done_n_oe_n !== 1'b1);
         repeat (10) tick;
         check(8'h0, {7'h0, user_mode});
         check(8'h0, {7'h0, user_clk_route});
         hold_done = 1'b0;
         for (i = 0; i < 10 && user_mode !== 1'b1; i = i + 1) tick;
         hung(user_mode !== 1'b1);
         repeat (3) tick;
         check({7'h0, m[0]}, {7'h0, jtag_route});
         check(8'h1, {7'h0, user_clk_route});
         $display("mode %0d finished", m);
      end
      wrap_up;
   end
endmodule // cps_pin_share_bench
